// ---- irq_route_ipc.sv ----
// interrupt routing to two cores with inter-core channels, AXI4-Lite registers
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module irq_route_ipc (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [irq_route_pkg::NUM_SRC-1:0] SRC_IRQ,
  input wire logic DEEP_SLEEP,
  input wire logic [3:0] SEC_LOCK_CH,
  input wire logic SEC_LOCK_ACQ,
  input wire logic SEC_LOCK_REL,
  output logic SEC_LOCK_DONE,
  output logic SEC_LOCK_GOT,
  output logic [irq_route_pkg::NUM_SRC-1:0] MAIN_IRQ,
  output logic MAIN_NMI,
  output logic MAIN_TOP_VLD,
  output logic [7:0] MAIN_TOP_SRC,
  output logic [2:0] MAIN_TOP_PRIO,
  output logic [irq_route_pkg::SEC_LINES-1:0] SEC_IRQ,
  output logic [irq_route_pkg::SEC_SOFT-1:0] SEC_SWI,
  output logic SEC_NMI,
  output logic SEC_TOP_VLD,
  output logic [3:0] SEC_TOP_IDX,
  output logic WAKE,
  output logic EVT_IRQ
);
  import irq_route_pkg::*;

  // ----------------------------------------
  // bus slave state
  // ----------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_have_r, w_have_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r, wmask_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [5:0] map_sel_r;
  logic [SRC_PAD-1:0] map_r [0:SEC_LINES-1];
  logic [7:0] prio_sel_r;
  logic [2:0] prio_r [0:NUM_SRC-1];
  logic [31:0] nmi_main_r, nmi_sec_r, wake_lo_r, sec_prio_r;
  logic [12:0] wake_hi_r;
  logic [7:0] soft_r;
  logic [31:0] evt_stat_r, evt_mask_r;
  logic [31:0] chan_data_r [0:CHANNELS-1];

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  logic [NUM_SRC-1:0] main_irq_r;
  logic main_nmi_r, sec_nmi_r, wake_r, evt_irq_r;
  logic main_vld_r, sec_vld_r, lock_done_r, lock_got_r;
  logic [7:0] main_src_r;
  logic [2:0] main_prio_r;
  logic [7:0] sec_irq_r;
  logic [3:0] sec_idx_r;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire aw_hs = AWVALID & awready_r;
  wire w_hs = WVALID & wready_r;
  wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
  wire [31:0] wbits = wdata_r & wmask_r;
  wire wsel_map_sel = wr_go & (waddr_r == OFF_MAP_SEL);
  wire wsel_map = wr_go & (waddr_r == OFF_MAP_DATA);
  wire wsel_prio_sel = wr_go & (waddr_r == OFF_PRIO_SEL);
  wire wsel_prio = wr_go & (waddr_r == OFF_PRIO_DATA);
  wire wsel_nmi_main = wr_go & (waddr_r == OFF_NMI_MAIN);
  wire wsel_nmi_sec = wr_go & (waddr_r == OFF_NMI_SEC);
  wire wsel_wake_lo = wr_go & (waddr_r == OFF_WAKE_LO);
  wire wsel_wake_hi = wr_go & (waddr_r == OFF_WAKE_HI);
  wire wsel_soft = wr_go & (waddr_r == OFF_SOFT);
  wire wsel_sec_prio = wr_go & (waddr_r == OFF_SEC_PRIO);
  wire wsel_stat = wr_go & (waddr_r == OFF_EVT_STAT);
  wire wsel_mask = wr_go & (waddr_r == OFF_EVT_MASK);
  wire wsel_trig = wr_go & (waddr_r == OFF_EVT_TRIG);
  wire wsel_lock = wr_go & (waddr_r[7:6] == REGION_LOCK);
  wire wsel_data = wr_go & (waddr_r[7:6] == REGION_DATA);
  wire w_known = (waddr_r[7:6] == REGION_LOCK) | (waddr_r[7:6] == REGION_DATA)
    | (waddr_r <= OFF_EVT_TRIG) & (waddr_r[1:0] == 2'h0);
  wire [2:0] map_line = map_sel_r[5:3];
  wire [7:0] map_base = {map_sel_r[2:0], 5'h00};
  wire prio_ok = prio_sel_r < SRC_LIMIT;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  wire ar_hs = ARVALID & arready_r;
  wire rd_lock = ar_hs & (ARADDR[7:6] == REGION_LOCK) & (ARADDR[1:0] == 2'h0);
  wire [3:0] rd_ch = ARADDR[5:2];
  wire [SRC_PAD-1:0] src_pad = {81'h0, SRC_IRQ};

  // ----------------------------------------
  // channel locks
  // ----------------------------------------
  logic [CHANNELS-1:0] m_acq, m_rel, s_acq, s_rel, m_got, s_got, rel_evt, held, by_sec;
  lock_state_t lock_st [0:CHANNELS-1];

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_lock
      assign m_acq[c] = rd_lock & (rd_ch == 4'(c));
      assign m_rel[c] = wsel_lock & (waddr_r[5:2] == 4'(c));
      assign s_acq[c] = SEC_LOCK_ACQ & (SEC_LOCK_CH == 4'(c));
      assign s_rel[c] = SEC_LOCK_REL & (SEC_LOCK_CH == 4'(c));
      assign held[c] = lock_st[c] != LOCK_FREE;
      assign by_sec[c] = lock_st[c] == LOCK_SEC;
      chan_lock u_lock (
        .clk(CLK),
        .rst(SYS_RST),
        .main_acq(m_acq[c]),
        .main_rel(m_rel[c]),
        .sec_acq(s_acq[c]),
        .sec_rel(s_rel[c]),
        .state(lock_st[c]),
        .main_got(m_got[c]),
        .sec_got(s_got[c]),
        .rel_evt(rel_evt[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // routing: secondary lines, nmi slots
  // ----------------------------------------
  logic [SEC_LINES-1:0] sec_line;
  logic [NMI_SLOTS-1:0] nmi_m_hit, nmi_s_hit;

  generate
    for (genvar l = 0; l < SEC_LINES; l++) begin : g_line
      assign sec_line[l] = |(map_r[l] & src_pad);
    end
    for (genvar k = 0; k < NMI_SLOTS; k++) begin : g_nmi
      // an index at or above the source count leaves the slot empty
      assign nmi_m_hit[k] = (nmi_main_r[8*k +: 8] < SRC_LIMIT) & src_pad[nmi_main_r[8*k +: 8]];
      assign nmi_s_hit[k] = (nmi_sec_r[8*k +: 8] < SRC_LIMIT) & src_pad[nmi_sec_r[8*k +: 8]];
    end
  endgenerate

  wire [WAKE_SRCS-1:0] wake_en = {wake_hi_r, wake_lo_r};
  // sources above the wake range have no path to the wake unit
  wire wake_nxt = DEEP_SLEEP & |(SRC_IRQ[WAKE_SRCS-1:0] & wake_en);
  wire [15:0] sec_act = {soft_r, sec_line};
  wire [31:0] evt_set = {rel_evt | (wsel_trig ? wbits[31:16] : 16'h0), wsel_trig ? wbits[15:0] : 16'h0};
  wire [31:0] evt_clr = wsel_stat ? wbits : 32'h0;

  // ----------------------------------------
  // priority resolution
  // ----------------------------------------
  logic main_found, sec_found;
  logic [7:0] main_best_src;
  logic [2:0] main_best;
  logic [3:0] sec_best_idx;
  logic [1:0] sec_best;

  // lower level wins; on equal level the lower index wins
  always_comb begin
    main_found = 1'b0;
    main_best = 3'h7;
    main_best_src = 8'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (SRC_IRQ[i] && (!main_found || prio_r[i] < main_best)) begin
        main_found = 1'b1;
        main_best = prio_r[i];
        main_best_src = 8'(i);
      end
    end
    sec_found = 1'b0;
    sec_best = 2'h3;
    sec_best_idx = 4'h0;
    for (int j = 0; j < 16; j++) begin
      if (sec_act[j] && (!sec_found || sec_prio_r[2*j +: 2] < sec_best)) begin
        sec_found = 1'b1;
        sec_best = sec_prio_r[2*j +: 2];
        sec_best_idx = 4'(j);
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] rd_val;
  logic rd_known;

  always_comb begin
    rd_val = 32'h0;
    rd_known = 1'b1;
    case (ARADDR)
      OFF_MAP_SEL: rd_val = {26'h0, map_sel_r};
      OFF_MAP_DATA: rd_val = map_r[map_line][map_base +: 32];
      OFF_PRIO_SEL: rd_val = {24'h0, prio_sel_r};
      OFF_PRIO_DATA: rd_val = prio_ok ? {29'h0, prio_r[prio_sel_r]} : 32'h0;
      OFF_NMI_MAIN: rd_val = nmi_main_r;
      OFF_NMI_SEC: rd_val = nmi_sec_r;
      OFF_WAKE_LO: rd_val = wake_lo_r;
      OFF_WAKE_HI: rd_val = {19'h0, wake_hi_r};
      OFF_SOFT: rd_val = {24'h0, soft_r};
      OFF_SEC_PRIO: rd_val = sec_prio_r;
      OFF_EVT_STAT: rd_val = evt_stat_r;
      OFF_EVT_MASK: rd_val = evt_mask_r;
      OFF_EVT_TRIG: rd_val = 32'h0;
      OFF_TOP_STAT: rd_val = {16'h0, main_vld_r, 4'h0, main_prio_r, main_src_r};
      OFF_LOCK_STAT: rd_val = {by_sec, held};
      default: begin
        if (ARADDR[7:6] == REGION_LOCK && ARADDR[1:0] == 2'h0) begin
          rd_val = {31'h0, m_got[rd_ch]};
        end else if (ARADDR[7:6] == REGION_DATA && ARADDR[1:0] == 2'h0) begin
          rd_val = chan_data_r[rd_ch];
        end else begin
          rd_known = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wmask_r <= 32'h0;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        aw_have_r <= 1'b1;
        waddr_r <= AWADDR;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        w_have_r <= 1'b1;
        wdata_r <= WDATA;
        wmask_r <= {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_known ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_known ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      map_sel_r <= 6'h00;
      prio_sel_r <= 8'h00;
      nmi_main_r <= NMI_SEL_RST;
      nmi_sec_r <= NMI_SEL_RST;
      wake_lo_r <= WAKE_LO_RST;
      wake_hi_r <= WAKE_HI_RST;
      soft_r <= 8'h00;
      sec_prio_r <= SEC_PRIO_RST;
      evt_mask_r <= EVT_MASK_RST;
      evt_stat_r <= 32'h0;
      for (int l = 0; l < SEC_LINES; l++) begin
        map_r[l] <= '0;
      end
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_r[i] <= MAIN_PRIO_RST;
      end
      for (int c = 0; c < CHANNELS; c++) begin
        chan_data_r[c] <= 32'h0;
      end
    end else begin
      if (wsel_map_sel) map_sel_r <= 6'(merge({26'h0, map_sel_r}, wdata_r, wmask_r));
      // bits past the last source stay zero so they never reach a line
      if (wsel_map) begin
        map_r[map_line][map_base +: 32] <= merge(map_r[map_line][map_base +: 32], wdata_r, wmask_r)
          & SRC_VALID[map_base +: 32];
      end
      if (wsel_prio_sel) prio_sel_r <= 8'(merge({24'h0, prio_sel_r}, wdata_r, wmask_r));
      if (wsel_prio && prio_ok && wmask_r[0]) prio_r[prio_sel_r] <= wdata_r[2:0];
      if (wsel_nmi_main) nmi_main_r <= merge(nmi_main_r, wdata_r, wmask_r);
      if (wsel_nmi_sec) nmi_sec_r <= merge(nmi_sec_r, wdata_r, wmask_r);
      if (wsel_wake_lo) wake_lo_r <= merge(wake_lo_r, wdata_r, wmask_r);
      if (wsel_wake_hi) wake_hi_r <= 13'(merge({19'h0, wake_hi_r}, wdata_r, wmask_r));
      if (wsel_soft) soft_r <= 8'(merge({24'h0, soft_r}, wdata_r, wmask_r));
      if (wsel_sec_prio) sec_prio_r <= merge(sec_prio_r, wdata_r, wmask_r);
      if (wsel_mask) evt_mask_r <= merge(evt_mask_r, wdata_r, wmask_r);
      if (wsel_data) chan_data_r[waddr_r[5:2]] <= merge(chan_data_r[waddr_r[5:2]], wdata_r, wmask_r);
      // a new event in the clearing cycle survives
      evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_set;
    end
  end

  // ----------------------------------------
  // outputs to the cores
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      main_irq_r <= '0;
      sec_irq_r <= 8'h00;
      main_nmi_r <= 1'b0;
      sec_nmi_r <= 1'b0;
      wake_r <= 1'b0;
      evt_irq_r <= 1'b0;
      main_vld_r <= 1'b0;
      main_src_r <= 8'h00;
      main_prio_r <= 3'h0;
      sec_vld_r <= 1'b0;
      sec_idx_r <= 4'h0;
      lock_done_r <= 1'b0;
      lock_got_r <= 1'b0;
    end else begin
      main_irq_r <= SRC_IRQ;
      sec_irq_r <= sec_line;
      main_nmi_r <= |nmi_m_hit;
      sec_nmi_r <= |nmi_s_hit;
      wake_r <= wake_nxt;
      evt_irq_r <= |(evt_stat_r & evt_mask_r);
      main_vld_r <= main_found;
      main_src_r <= main_best_src;
      main_prio_r <= main_best;
      sec_vld_r <= sec_found;
      sec_idx_r <= sec_best_idx;
      lock_done_r <= SEC_LOCK_ACQ | SEC_LOCK_REL;
      if (SEC_LOCK_ACQ) begin
        lock_got_r <= |s_got;
      end
    end
  end

  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign MAIN_IRQ = main_irq_r;
  assign SEC_IRQ = sec_irq_r;
  assign SEC_SWI = soft_r;
  assign MAIN_NMI = main_nmi_r;
  assign SEC_NMI = sec_nmi_r;
  assign WAKE = wake_r;
  assign EVT_IRQ = evt_irq_r;
  assign MAIN_TOP_VLD = main_vld_r;
  assign MAIN_TOP_SRC = main_src_r;
  assign MAIN_TOP_PRIO = main_prio_r;
  assign SEC_TOP_VLD = sec_vld_r;
  assign SEC_TOP_IDX = sec_idx_r;
  assign SEC_LOCK_DONE = lock_done_r;
  assign SEC_LOCK_GOT = lock_got_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_main_direct_map: assert property (@(posedge CLK) disable iff (SYS_RST)
    !$past(SYS_RST) |-> MAIN_IRQ == $past(SRC_IRQ))
    else $error("main request line does not follow its source");
  a_sec_line_or: assert property (@(posedge CLK) disable iff (SYS_RST)
    (SRC_IRQ[4] && map_r[2][4]) |=> SEC_IRQ[2])
    else $error("mapped source did not raise its secondary line");
  a_soft_only_sw: assert property (@(posedge CLK) disable iff (SYS_RST)
    !$stable(SEC_SWI) |-> $past(wsel_soft))
    else $error("software interrupt moved without a register write");
  a_top_is_active: assert property (@(posedge CLK) disable iff (SYS_RST)
    (MAIN_TOP_VLD && !$past(wsel_prio)) |-> main_irq_r[MAIN_TOP_SRC] && prio_r[MAIN_TOP_SRC] == MAIN_TOP_PRIO)
    else $error("reported top source was not pending at its level");
  a_nmi_slot_fires: assert property (@(posedge CLK) disable iff (SYS_RST)
    (nmi_main_r[7:0] < SRC_LIMIT && src_pad[nmi_main_r[7:0]]) |=> MAIN_NMI)
    else $error("selected source did not assert main nmi");
  a_wake_only_sleep: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!DEEP_SLEEP || SRC_IRQ[WAKE_SRCS-1:0] == '0) |=> !WAKE)
    else $error("wake raised outside deep sleep or by no wake source");
  a_notify_irq: assert property (@(posedge CLK) disable iff (SYS_RST)
    (wsel_trig && wbits[0] && evt_mask_r[0]) |-> ##2 EVT_IRQ)
    else $error("notify trigger did not interrupt the other core");
endmodule : irq_route_ipc
`default_nettype wire

// ---- irq_route_pkg.sv ----
// constants shared by the interrupt routing and inter-core channel block
package irq_route_pkg;
  localparam int NUM_SRC = 175;
  localparam int SRC_PAD = 256;
  localparam int SEC_LINES = 8;
  localparam int SEC_SOFT = 8;
  localparam int NMI_SLOTS = 4;
  localparam int WAKE_SRCS = 45;
  localparam int CHANNELS = 16;
  localparam logic [7:0] SRC_LIMIT = 8'haf;
  localparam logic [SRC_PAD-1:0] SRC_VALID = (256'h1 << NUM_SRC) - 256'h1;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_MAP_SEL = 8'h00;
  localparam logic [7:0] OFF_MAP_DATA = 8'h04;
  localparam logic [7:0] OFF_PRIO_SEL = 8'h08;
  localparam logic [7:0] OFF_PRIO_DATA = 8'h0c;
  localparam logic [7:0] OFF_NMI_MAIN = 8'h10;
  localparam logic [7:0] OFF_NMI_SEC = 8'h14;
  localparam logic [7:0] OFF_WAKE_LO = 8'h18;
  localparam logic [7:0] OFF_WAKE_HI = 8'h1c;
  localparam logic [7:0] OFF_SOFT = 8'h20;
  localparam logic [7:0] OFF_SEC_PRIO = 8'h24;
  localparam logic [7:0] OFF_EVT_STAT = 8'h28;
  localparam logic [7:0] OFF_EVT_MASK = 8'h2c;
  localparam logic [7:0] OFF_EVT_TRIG = 8'h30;
  localparam logic [7:0] OFF_TOP_STAT = 8'h34;
  localparam logic [7:0] OFF_LOCK_STAT = 8'h38;
  localparam logic [1:0] REGION_LOCK = 2'h1;
  localparam logic [1:0] REGION_DATA = 2'h2;

  // ----------------------------------------
  // reset values and answers
  // ----------------------------------------
  localparam logic [31:0] NMI_SEL_RST = 32'hffff_ffff;
  localparam logic [31:0] WAKE_LO_RST = 32'hffff_ffff;
  localparam logic [12:0] WAKE_HI_RST = 13'h1fff;
  localparam logic [31:0] SEC_PRIO_RST = 32'hffff_ffff;
  localparam logic [2:0] MAIN_PRIO_RST = 3'h7;
  localparam logic [31:0] EVT_MASK_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    LOCK_FREE = 2'b00,
    LOCK_MAIN = 2'b01,
    LOCK_SEC = 2'b10
  } lock_state_t;
endpackage : irq_route_pkg

// ---- chan_lock.sv ----
// lock of one inter-core channel with same-cycle arbitration
`timescale 1ns/10ps
`default_nettype none
module chan_lock (
  input wire logic clk,
  input wire logic rst,
  input wire logic main_acq,
  input wire logic main_rel,
  input wire logic sec_acq,
  input wire logic sec_rel,
  output var irq_route_pkg::lock_state_t state,
  output logic main_got,
  output logic sec_got,
  output logic rel_evt
);
  import irq_route_pkg::*;

  lock_state_t state_r;
  lock_state_t state_nxt;

  // main core wins a tie; the loser simply sees the lock held
  assign main_got = (state_r == LOCK_FREE) & main_acq;
  assign sec_got = (state_r == LOCK_FREE) & sec_acq & ~main_acq;
  // only the owner can free the lock
  assign rel_evt = ((state_r == LOCK_MAIN) & main_rel) | ((state_r == LOCK_SEC) & sec_rel);
  assign state = state_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LOCK_FREE: begin
        if (main_acq) begin
          state_nxt = LOCK_MAIN;
        end else if (sec_acq) begin
          state_nxt = LOCK_SEC;
        end
      end
      LOCK_MAIN: begin
        if (main_rel) begin
          state_nxt = LOCK_FREE;
        end
      end
      LOCK_SEC: begin
        if (sec_rel) begin
          state_nxt = LOCK_FREE;
        end
      end
      default: begin
        state_nxt = LOCK_FREE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= LOCK_FREE;
    end else begin
      state_r <= state_nxt;
    end
  end

  a_lock_one_winner: assert property (@(posedge clk) disable iff (rst)
    (main_acq && sec_acq && state_r == LOCK_FREE) |=> state_r == LOCK_MAIN)
    else $error("collision did not go to exactly one core");
  a_lock_held_kept: assert property (@(posedge clk) disable iff (rst)
    (state_r == LOCK_SEC && !sec_rel) |-> !main_got ##1 state_r == LOCK_SEC)
    else $error("lock held by secondary core was taken away");
endmodule : chan_lock
`default_nettype wire

// ---- sec_core_model.sv ----
// secondary core model driving the lock port of the inter-core channels
`timescale 1ns/10ps
`default_nettype none
module sec_core_model (
  input wire logic clk,
  input wire logic [3:0] ch,
  input wire logic acq,
  input wire logic rel,
  output logic [3:0] lock_ch,
  output logic lock_acq,
  output logic lock_rel
);
  // between requests the channel lines carry the inverse, so a stale number is never mistaken for a request
  always_ff @(posedge clk) begin
    lock_acq <= acq;
    lock_rel <= rel;
    lock_ch <= (acq | rel) ? ch : ~ch;
  end
endmodule : sec_core_model
`default_nettype wire

// ---- irq_route_ipc_tb.sv ----
// self-checking testbench of the interrupt routing and inter-core channel block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t %s", $time, m); end end
module irq_route_ipc_tb;
  import irq_route_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done, got, nmi, sec_nmi, wake, evt_irq, mtv, stv;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [NUM_SRC-1:0] src = '0, main_irq;
  logic [191:0] rnd;
  logic ds = 1'b0, s_acq = 1'b0, s_rel = 1'b0, l_acq, l_rel, g;
  logic [3:0] s_ch = 4'h0, l_ch, sti;
  logic [7:0] sec_irq, swi, mts;
  logic [2:0] mtp;
  int errors = 0, check_count = 0, seed = 13, i;

  irq_route_ipc i_dut (.CLK(clk), .SYS_RST(sys_rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .SRC_IRQ(src), .DEEP_SLEEP(ds), .SEC_LOCK_CH(l_ch), .SEC_LOCK_ACQ(l_acq),
    .SEC_LOCK_REL(l_rel), .SEC_LOCK_DONE(done), .SEC_LOCK_GOT(got), .MAIN_IRQ(main_irq), .MAIN_NMI(nmi),
    .MAIN_TOP_VLD(mtv), .MAIN_TOP_SRC(mts), .MAIN_TOP_PRIO(mtp), .SEC_IRQ(sec_irq), .SEC_SWI(swi),
    .SEC_NMI(sec_nmi), .SEC_TOP_VLD(stv), .SEC_TOP_IDX(sti), .WAKE(wake), .EVT_IRQ(evt_irq));
  sec_core_model i_sec (.clk(clk), .ch(s_ch), .acq(s_acq), .rel(s_rel), .lock_ch(l_ch), .lock_acq(l_acq),
    .lock_rel(l_rel));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // --------------------------------------------------
  // bus, lock port and source drivers
  // --------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) begin errors++; conclude(); end
    `CHK(bresp, er, "write response")
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) begin errors++; conclude(); end
    v = rdata;
    rr = rresp;
  endtask : rd

  task automatic sec_lock(input logic [3:0] c, input logic take, output logic res);
    int n;
    @(posedge clk);
    s_ch <= c; s_acq <= take; s_rel <= !take;
    @(posedge clk);
    s_acq <= 1'b0; s_rel <= 1'b0;
    for (n = 0; n < 10 && done !== 1'b1; n++) @(posedge clk);
    if (n == 10) begin errors++; conclude(); end
    res = got;
  endtask : sec_lock

  task automatic drive(input logic [NUM_SRC-1:0] s, input logic sl);
    int t;
    logic ln;
    // with every level still at reset the lowest active source leads
    t = 0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (s[k]) t = k;
    end
    ln = |(s[31:0] & 32'hf0);
    @(posedge clk);
    src <= s; ds <= sl;
    @(posedge clk);
    #1;
    `CHK(main_irq, s, "main request lines")
    `CHK(sec_irq, ln ? 8'h04 : 8'h00, "mapped secondary lines")
    `CHK(nmi, s[5], "main nmi")
    `CHK(sec_nmi, 1'b0, "empty secondary nmi slots")
    `CHK(wake, sl & |s[44:0], "deep sleep wake")
    `CHK(mtv, |s, "main top valid")
    `CHK(mts, 8'(t), "main top source")
    `CHK(mtp, 3'h7, "main top level")
    `CHK(stv, 1'b1, "secondary top valid")
    `CHK(sti, ln ? 4'h2 : 4'h8, "secondary top index")
  endtask : drive

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_NMI_SEC, d, r); `CHK(d, NMI_SEL_RST, "nmi select reset")
    rd(OFF_SEC_PRIO, d, r); `CHK(d, SEC_PRIO_RST, "secondary priority reset")
    rd(8'h3c, d, r); `CHK(r, RESP_DECERR, "unmapped read")
    wr(8'h3c, 32'h1, RESP_DECERR);
    wr(OFF_MAP_SEL, 32'h10, RESP_OKAY);
    wr(OFF_MAP_DATA, 32'hf0, RESP_OKAY);
    wr(OFF_NMI_MAIN, 32'hffff_ff05, RESP_OKAY);
    wr(OFF_SOFT, 32'ha5, RESP_OKAY);
    `CHK(swi, 8'ha5, "software interrupts")
    for (i = 0; i < 20; i++) begin
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      drive(rnd[NUM_SRC-1:0], rnd[191]);
    end
    drive(175'h1 << 45, 1'b1);
    drive(175'h1 << 44, 1'b0);
    @(posedge clk);
    src <= 175'h88;
    wr(OFF_PRIO_SEL, 32'h7, RESP_OKAY);
    wr(OFF_PRIO_DATA, 32'h2, RESP_OKAY);
    rd(OFF_TOP_STAT, d, r); `CHK(d, 32'h0000_8207, "top priority source")
    `CHK(mts, 8'h07, "top source port")
    // only application channels below eight are touched
    rd(8'h4c, d, r); `CHK(d[0], 1'b1, "main acquire free lock")
    sec_lock(4'h3, 1'b1, g); `CHK(g, 1'b0, "held lock refused")
    sec_lock(4'h5, 1'b1, g); `CHK(g, 1'b1, "secondary acquire")
    rd(8'h54, d, r); `CHK(d[0], 1'b0, "main sees held lock")
    rd(OFF_LOCK_STAT, d, r); `CHK(d, 32'h0020_0028, "lock owners")
    wr(OFF_EVT_MASK, 32'h0020_0001, RESP_OKAY);
    sec_lock(4'h5, 1'b0, g);
    rd(OFF_EVT_STAT, d, r); `CHK(d, 32'h0020_0000, "release event")
    `CHK(evt_irq, 1'b1, "unmasked event raises")
    wr(OFF_EVT_STAT, 32'h0020_0000, RESP_OKAY);
    wr(8'h4c, 32'h0, RESP_OKAY);
    wr(OFF_EVT_TRIG, 32'h1, RESP_OKAY);
    rd(OFF_EVT_STAT, d, r); `CHK(d, 32'h0008_0001, "clear, release and notify")
    `CHK(evt_irq, 1'b1, "unmasked notify raises")
    wr(OFF_EVT_STAT, 32'h1, RESP_OKAY);
    rd(OFF_EVT_STAT, d, r); `CHK(d, 32'h0008_0000, "notify cleared, release kept")
    `CHK(evt_irq, 1'b0, "masked events stay quiet")
    // both cores reach for free channel six in the same cycle
    fork
      sec_lock(4'h6, 1'b1, g);
      begin
        @(posedge clk);
        rd(8'h58, d, r);
      end
    join
    `CHK(d[0], 1'b1, "main wins collision")
    `CHK(g, 1'b0, "secondary loses collision")
    conclude();
  end
endmodule : irq_route_ipc_tb
`default_nettype wire
